// ---- core/mcd_defs.svh ----
// constants of the motion command decoder
//
// Summary of operation
// - numbers 1-4: rotate, halt, move to position
// - numbers 30-32: set, get, capture coordinate
// - numbers 5-12: axis and global parameter access
// - axis parameters per axis, globals module-wide
// - 20 compare, 21 conditional jump, 22 jump
// - 23 calls subroutine, 24 returns from it
// - 27 waits for event, 28 ends program
// - 14 drives output port, 15 reads input
// - 19 combines accumulator with constant operand
// - 33 combines accumulator with x register
// - 34/35 copy accumulator into axis/global parameter
// - 39 copies accumulator into coordinate slot
// - one accumulator and one x register exist
// - standalone reads load result into accumulator
// - x register loadable from the accumulator
// - direct reads leave the accumulator untouched
// - host queries never disturb a running program
// - 25/26 unmask/mask, 37 handler, 38 interrupt return
// - status 100 marks successful execution
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// ****************
// command numbers
// ****************
`define MCD_CMD_ROTATE_RIGHT 8'h01
`define MCD_CMD_ROTATE_LEFT 8'h02
`define MCD_CMD_HALT_MOTOR 8'h03
`define MCD_CMD_MOVE_TO_POS 8'h04
`define MCD_CMD_WR_AXIS 8'h05
`define MCD_CMD_RD_AXIS 8'h06
`define MCD_CMD_STORE_AXIS 8'h07
`define MCD_CMD_RESTORE_AXIS 8'h08
`define MCD_CMD_WR_GLOBAL 8'h09
`define MCD_CMD_RD_GLOBAL 8'h0A
`define MCD_CMD_STORE_GLOBAL 8'h0B
`define MCD_CMD_RESTORE_GLOBAL 8'h0C
`define MCD_CMD_DRIVE_OUT 8'h0E
`define MCD_CMD_READ_IN 8'h0F
`define MCD_CMD_ALU_CONST 8'h13
`define MCD_CMD_COMPARE 8'h14
`define MCD_CMD_JUMP_COND 8'h15
`define MCD_CMD_JUMP_ALWAYS 8'h16
`define MCD_CMD_CALL_SUB 8'h17
`define MCD_CMD_RET_SUB 8'h18
`define MCD_CMD_UNMASK_IRQ 8'h19
`define MCD_CMD_MASK_IRQ 8'h1A
`define MCD_CMD_WAIT_EVENT 8'h1B
`define MCD_CMD_END_PROG 8'h1C
`define MCD_CMD_SET_COORD 8'h1E
`define MCD_CMD_GET_COORD 8'h1F
`define MCD_CMD_CAPT_COORD 8'h20
`define MCD_CMD_ALU_X 8'h21
`define MCD_CMD_ACC_TO_AXIS 8'h22
`define MCD_CMD_ACC_TO_GLOBAL 8'h23
`define MCD_CMD_IRQ_HANDLER 8'h25
`define MCD_CMD_RET_IRQ 8'h26
`define MCD_CMD_ACC_TO_COORD 8'h27

// ****************
// status and sizes
// ****************
`define MCD_ST_OK 8'h64
`define MCD_ST_BAD_CMD 8'h02
`define MCD_ST_BAD_TYPE 8'h03
`define MCD_COORD_SLOTS 8

`endif

// ---- core/mcd_pkg.sv ----
// types of the motion command decoder
`include "mcd_defs.svh"
package mcd_pkg;
  typedef enum logic [7:0] {alu_add = 8'h00, alu_sub = 8'h01, alu_mul = 8'h02,
    alu_and = 8'h03, alu_or = 8'h04, alu_xor = 8'h05, alu_not = 8'h06,
    alu_load = 8'h07, alu_x_from_acc = 8'h08, alu_acc_from_x = 8'h09,
    alu_swap = 8'h0A} mcd_alu_e;
  typedef enum logic [7:0] {cond_eq = 8'h00, cond_ne = 8'h01, cond_gt = 8'h02,
    cond_ge = 8'h03, cond_lt = 8'h04, cond_le = 8'h05} mcd_cond_e;
  typedef enum logic [4:0] {op_none, op_rotate_right, op_rotate_left, op_halt_motor,
    op_move_to_position, op_write_axis_parameter, op_read_axis_parameter,
    op_store_axis_parameter, op_restore_axis_parameter, op_write_global_parameter,
    op_read_global_parameter, op_store_global_parameter, op_restore_global_parameter,
    op_drive_output_port, op_read_input_port, op_jump_conditional, op_jump_always,
    op_call_subroutine, op_return_from_subroutine, op_wait_event, op_end_program,
    op_unmask_interrupt_source, op_mask_interrupt_source,
    op_set_interrupt_handler_address, op_return_from_interrupt} mcd_op_e;
  typedef enum logic [1:0] {fsm_idle, fsm_wait, fsm_reply} mcd_fsm_e;
  typedef struct packed {
    logic standalone;
    logic [7:0] number;
    logic [7:0] ctype;
    logic [7:0] motor;
    logic [31:0] value;
  } mcd_cmd_s;
  typedef struct packed {
    mcd_op_e kind;
    logic [7:0] ctype;
    logic [7:0] motor;
    logic [31:0] value;
    logic taken;
  } mcd_op_s;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] number;
    logic [31:0] value;
  } mcd_reply_s;
  typedef struct packed {
    logic ok;
    logic [31:0] val;
  } mcd_res_s;
  typedef struct packed {
    mcd_fsm_e fsm;
    logic cmd_ready;
    logic op_valid;
    mcd_op_s op;
    logic reply_valid;
    mcd_reply_s reply;
    logic [31:0] acc;
    logic [31:0] xreg;
    logic flag_eq;
    logic flag_lt;
    logic [31:0] ctx_acc;
    logic [31:0] ctx_x;
    logic ctx_eq;
    logic ctx_lt;
    logic pend_sa;
    logic [`MCD_COORD_SLOTS-1:0][31:0] coord;
  } mcd_state_s;
endpackage : mcd_pkg

// ---- core/mcd_decoder.sv ----
// motion command decoder: dispatch, accumulator, x register, coordinates
`timescale 1ns/10ps
`default_nettype none
`include "mcd_defs.svh"

module mcd_decoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command in
  input wire logic cmd_valid,
  input wire mcd_pkg::mcd_cmd_s cmd,
  output logic cmd_ready,
  // operation to executor
  output logic op_valid,
  output mcd_pkg::mcd_op_s op,
  // read data from executor
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  // actual motor position
  input wire logic [31:0] actual_pos,
  // interrupt entry from sequencer
  input wire logic irq_entry,
  // reply
  output logic reply_valid,
  output mcd_pkg::mcd_reply_s reply,
  // calculation registers
  output logic [31:0] acc,
  output logic [31:0] xreg
);
  import mcd_pkg::*;

  // ****************
  // helpers
  // ****************
  function automatic mcd_res_s alu_fn(input logic [7:0] code, input logic [31:0] a,
                                      input logic [31:0] b);
    logic [63:0] p;
    mcd_res_s r;
    p = {32'h0, a} * {32'h0, b};
    r.ok = 1'b1;
    r.val = a;
    case (code)
      alu_add: r.val = a + b;
      alu_sub: r.val = a - b;
      alu_mul: r.val = p[31:0];
      alu_and: r.val = a & b;
      alu_or: r.val = a | b;
      alu_xor: r.val = a ^ b;
      alu_not: r.val = ~a;
      alu_load: r.val = b;
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction : alu_fn

  function automatic logic [1:0] cond_fn(input logic [7:0] code, input logic eq,
                                         input logic lt);
    logic [1:0] r;
    r = 2'b10;
    case (code)
      cond_eq: r[0] = eq;
      cond_ne: r[0] = ~eq;
      cond_gt: r[0] = ~eq & ~lt;
      cond_ge: r[0] = ~lt;
      cond_lt: r[0] = lt;
      cond_le: r[0] = lt | eq;
      default: r = 2'b00;
    endcase
    return r;
  endfunction : cond_fn

  function automatic logic slot_ok(input logic [7:0] idx);
    return idx < 8'(`MCD_COORD_SLOTS);
  endfunction : slot_ok

  // ****************
  // state
  // ****************
  mcd_state_s s_r;
  mcd_state_s s_nxt;

  always_comb begin
    mcd_op_e kind;
    logic ext;
    logic rd;
    logic bad_cmd;
    logic bad_type;
    logic [1:0] c;
    logic [2:0] slot;
    mcd_res_s ar;
    kind = op_none;
    ext = 1'b0;
    rd = 1'b0;
    bad_cmd = 1'b0;
    bad_type = 1'b0;
    c = 2'b00;
    slot = cmd.ctype[2:0];
    ar = '0;
    s_nxt = s_r;
    s_nxt.op_valid = 1'b0;
    s_nxt.reply_valid = 1'b0;
    // context snapshot for an interrupt handler
    if (irq_entry) begin
      s_nxt.ctx_acc = s_r.acc;
      s_nxt.ctx_x = s_r.xreg;
      s_nxt.ctx_eq = s_r.flag_eq;
      s_nxt.ctx_lt = s_r.flag_lt;
    end
    case (s_r.fsm)
      fsm_idle: begin
        s_nxt.cmd_ready = 1'b1;
        if (cmd_valid && s_r.cmd_ready) begin
          s_nxt.cmd_ready = 1'b0;
          s_nxt.fsm = fsm_reply;
          s_nxt.reply_valid = 1'b1;
          s_nxt.reply.number = cmd.number;
          s_nxt.reply.status = `MCD_ST_OK;
          s_nxt.reply.value = cmd.value;
          s_nxt.op.ctype = cmd.ctype;
          s_nxt.op.motor = cmd.motor;
          s_nxt.op.value = cmd.value;
          s_nxt.op.taken = 1'b0;
          s_nxt.pend_sa = cmd.standalone;
          case (cmd.number)
            `MCD_CMD_ROTATE_RIGHT: begin
              kind = op_rotate_right;
              ext = 1'b1;
            end
            `MCD_CMD_ROTATE_LEFT: begin
              kind = op_rotate_left;
              ext = 1'b1;
            end
            `MCD_CMD_HALT_MOTOR: begin
              kind = op_halt_motor;
              ext = 1'b1;
            end
            `MCD_CMD_MOVE_TO_POS: begin
              kind = op_move_to_position;
              ext = 1'b1;
            end
            `MCD_CMD_WR_AXIS: begin
              kind = op_write_axis_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_RD_AXIS: begin
              kind = op_read_axis_parameter;
              ext = 1'b1;
              rd = 1'b1;
            end
            `MCD_CMD_STORE_AXIS: begin
              kind = op_store_axis_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_RESTORE_AXIS: begin
              kind = op_restore_axis_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_WR_GLOBAL: begin
              kind = op_write_global_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_RD_GLOBAL: begin
              kind = op_read_global_parameter;
              ext = 1'b1;
              rd = 1'b1;
            end
            `MCD_CMD_STORE_GLOBAL: begin
              kind = op_store_global_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_RESTORE_GLOBAL: begin
              kind = op_restore_global_parameter;
              ext = 1'b1;
            end
            `MCD_CMD_DRIVE_OUT: begin
              kind = op_drive_output_port;
              ext = 1'b1;
            end
            `MCD_CMD_READ_IN: begin
              kind = op_read_input_port;
              ext = 1'b1;
              rd = 1'b1;
            end
            `MCD_CMD_ALU_CONST: begin
              ar = alu_fn(cmd.ctype, s_r.acc, cmd.value);
              bad_type = ~ar.ok;
              if (ar.ok) s_nxt.acc = ar.val;
              s_nxt.reply.value = ar.ok ? ar.val : s_r.acc;
            end
            `MCD_CMD_COMPARE: begin
              s_nxt.flag_eq = s_r.acc == cmd.value;
              s_nxt.flag_lt = $signed(s_r.acc) < $signed(cmd.value);
            end
            `MCD_CMD_JUMP_COND: begin
              c = cond_fn(cmd.ctype, s_r.flag_eq, s_r.flag_lt);
              bad_type = ~c[1];
              kind = op_jump_conditional;
              ext = c[1];
              s_nxt.op.taken = c[0];
            end
            `MCD_CMD_JUMP_ALWAYS: begin
              kind = op_jump_always;
              ext = 1'b1;
              s_nxt.op.taken = 1'b1;
            end
            `MCD_CMD_CALL_SUB: begin
              kind = op_call_subroutine;
              ext = 1'b1;
            end
            `MCD_CMD_RET_SUB: begin
              kind = op_return_from_subroutine;
              ext = 1'b1;
            end
            `MCD_CMD_WAIT_EVENT: begin
              kind = op_wait_event;
              ext = 1'b1;
            end
            `MCD_CMD_END_PROG: begin
              kind = op_end_program;
              ext = 1'b1;
            end
            `MCD_CMD_UNMASK_IRQ: begin
              kind = op_unmask_interrupt_source;
              ext = 1'b1;
            end
            `MCD_CMD_MASK_IRQ: begin
              kind = op_mask_interrupt_source;
              ext = 1'b1;
            end
            `MCD_CMD_IRQ_HANDLER: begin
              kind = op_set_interrupt_handler_address;
              ext = 1'b1;
            end
            `MCD_CMD_RET_IRQ: begin
              kind = op_return_from_interrupt;
              ext = 1'b1;
              s_nxt.acc = s_r.ctx_acc;
              s_nxt.xreg = s_r.ctx_x;
              s_nxt.flag_eq = s_r.ctx_eq;
              s_nxt.flag_lt = s_r.ctx_lt;
            end
            `MCD_CMD_SET_COORD: begin
              bad_type = ~slot_ok(cmd.ctype);
              if (!bad_type) s_nxt.coord[slot] = cmd.value;
            end
            `MCD_CMD_GET_COORD: begin
              bad_type = ~slot_ok(cmd.ctype);
              s_nxt.reply.value = bad_type ? 32'h0 : s_r.coord[slot];
              // direct queries keep the program's accumulator intact
              if (!bad_type && cmd.standalone) s_nxt.acc = s_r.coord[slot];
            end
            `MCD_CMD_CAPT_COORD: begin
              bad_type = ~slot_ok(cmd.ctype);
              if (!bad_type) s_nxt.coord[slot] = actual_pos;
            end
            `MCD_CMD_ALU_X: begin
              s_nxt.reply.value = s_r.acc;
              case (cmd.ctype)
                alu_x_from_acc: s_nxt.xreg = s_r.acc;
                alu_acc_from_x: s_nxt.acc = s_r.xreg;
                alu_swap: begin
                  s_nxt.acc = s_r.xreg;
                  s_nxt.xreg = s_r.acc;
                end
                default: begin
                  ar = alu_fn(cmd.ctype, s_r.acc, s_r.xreg);
                  bad_type = ~ar.ok;
                  if (ar.ok) s_nxt.acc = ar.val;
                end
              endcase
            end
            `MCD_CMD_ACC_TO_AXIS: begin
              kind = op_write_axis_parameter;
              ext = 1'b1;
              s_nxt.op.value = s_r.acc;
            end
            `MCD_CMD_ACC_TO_GLOBAL: begin
              kind = op_write_global_parameter;
              ext = 1'b1;
              s_nxt.op.value = s_r.acc;
            end
            `MCD_CMD_ACC_TO_COORD: begin
              bad_type = ~slot_ok(cmd.ctype);
              if (!bad_type) s_nxt.coord[slot] = s_r.acc;
            end
            default: bad_cmd = 1'b1;
          endcase
          if (bad_cmd) begin
            s_nxt.reply.status = `MCD_ST_BAD_CMD;
            s_nxt.reply.value = 32'h0;
          end else if (bad_type) begin
            s_nxt.reply.status = `MCD_ST_BAD_TYPE;
          end
          if (ext) begin
            s_nxt.op_valid = 1'b1;
            s_nxt.op.kind = kind;
          end
          // reads hold the reply until the executor answers
          if (rd) begin
            s_nxt.fsm = fsm_wait;
            s_nxt.reply_valid = 1'b0;
          end
        end
      end
      fsm_wait: begin
        if (rsp_valid) begin
          s_nxt.fsm = fsm_reply;
          s_nxt.reply_valid = 1'b1;
          s_nxt.reply.value = rsp_data;
          // a host query between program steps must not touch program state
          if (s_r.pend_sa) s_nxt.acc = rsp_data;
        end
      end
      fsm_reply: begin
        s_nxt.fsm = fsm_idle;
        s_nxt.cmd_ready = 1'b1;
      end
      default: begin
        s_nxt.fsm = fsm_idle;
        s_nxt.cmd_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************
  // outputs
  // ****************
  assign cmd_ready = s_r.cmd_ready;
  assign op_valid = s_r.op_valid;
  assign op = s_r.op;
  assign reply_valid = s_r.reply_valid;
  assign reply = s_r.reply;
  assign acc = s_r.acc;
  assign xreg = s_r.xreg;

endmodule : mcd_decoder
`default_nettype wire

// ---- tb/mcd_decoder_properties.sv ----
// port checker of the motion command decoder
`timescale 1ns/10ps
`default_nettype none
`include "mcd_defs.svh"
module mcd_decoder_properties
  import mcd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command side
  input wire logic cmd_valid,
  input wire mcd_pkg::mcd_cmd_s cmd,
  input wire logic cmd_ready,
  // executor side
  input wire logic op_valid,
  input wire mcd_pkg::mcd_op_s op,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic [31:0] actual_pos,
  input wire logic irq_entry,
  // reply and registers
  input wire logic reply_valid,
  input wire mcd_pkg::mcd_reply_s reply,
  input wire logic [31:0] acc,
  input wire logic [31:0] xreg
);
  logic take;
  logic is_rd;
  logic rd_direct_r;
  logic rd_sa_r;
  assign take = cmd_valid & cmd_ready;
  assign is_rd = cmd.number inside {`MCD_CMD_RD_AXIS, `MCD_CMD_RD_GLOBAL, `MCD_CMD_READ_IN};
  // an executor read stays pending until its reply cycle is over
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_direct_r <= 1'b0;
      rd_sa_r <= 1'b0;
    end else if (take) begin
      rd_direct_r <= is_rd & ~cmd.standalone;
      rd_sa_r <= is_rd & cmd.standalone;
    end else if (reply_valid) begin
      rd_direct_r <= 1'b0;
      rd_sa_r <= 1'b0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rotate_right_op: assert property (take && cmd.number == `MCD_CMD_ROTATE_RIGHT
    |=> op_valid && op.kind == op_rotate_right) else $error("rotate right not forwarded");
  a_halt_op: assert property (take && cmd.number == `MCD_CMD_HALT_MOTOR
    |=> op_valid && op.kind == op_halt_motor) else $error("halt not forwarded");
  a_axis_read_op: assert property (take && cmd.number == `MCD_CMD_RD_AXIS
    |=> op_valid && op.kind == op_read_axis_parameter) else $error("axis read not forwarded");
  a_global_write_op: assert property (take && cmd.number == `MCD_CMD_WR_GLOBAL
    |=> op_valid && op.kind == op_write_global_parameter) else $error("global write lost");
  a_status_ok: assert property (take && !is_rd && cmd.number == `MCD_CMD_ROTATE_LEFT
    |=> reply_valid && reply.status == `MCD_ST_OK && !cmd_ready ##1 cmd_ready)
    else $error("success reply wrong");
  a_bad_number: assert property (take && cmd.number == 8'h00
    |=> reply_valid && reply.status == `MCD_ST_BAD_CMD && !op_valid
    && acc == $past(acc) && xreg == $past(xreg)) else $error("invalid number acted on");
  a_direct_read_acc: assert property (rd_direct_r |-> $stable(acc))
    else $error("direct read changed accumulator");
  a_sa_read_acc: assert property (rsp_valid && rd_sa_r && !reply_valid
    |=> reply_valid && acc == $past(rsp_data) && reply.value == acc)
    else $error("program read not loaded");
  a_copy_acc_axis: assert property (take && cmd.number == `MCD_CMD_ACC_TO_AXIS
    |=> op_valid && op.kind == op_write_axis_parameter && op.value == $past(acc))
    else $error("accumulator copy wrong");
  c_sa_read: cover property (rd_sa_r && reply_valid);
  c_alu_x: cover property (take && cmd.number == `MCD_CMD_ALU_X);
  c_irq: cover property (irq_entry ##[1:50] take && cmd.number == `MCD_CMD_RET_IRQ);
endmodule : mcd_decoder_properties
bind mcd_decoder mcd_decoder_properties i_props (.ref_clk, .rst, .cmd_valid, .cmd, .cmd_ready,
  .op_valid, .op, .rsp_valid, .rsp_data, .actual_pos, .irq_entry, .reply_valid, .reply,
  .acc, .xreg);
`default_nettype wire

// ---- tb/mcd_exec_model.sv ----
// executor model: parameter store and read answers
`timescale 1ns/10ps
`default_nettype none
module mcd_exec_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // operation in
  input wire logic op_valid,
  input wire mcd_pkg::mcd_op_s op,
  input wire logic slow,
  // read answer
  output logic rsp_valid,
  output logic [31:0] rsp_data
);
  import mcd_pkg::*;
  logic [31:0] ax[int];
  logic [31:0] gl[int];
  logic [31:0] held;
  int wait_n;
  initial begin
    rsp_valid = 1'b0;
    rsp_data = 32'h0;
    wait_n = -1;
  end
  always @(posedge ref_clk) begin
    #1;
    rsp_valid = 1'b0;
    // outside the answer cycle the data flips to its complement every cycle
    rsp_data = ~rsp_data;
    if (rst) begin
      wait_n = -1;
    end else if (op_valid) begin
      case (op.kind)
        op_write_axis_parameter: ax[{op.ctype, op.motor}] = op.value;
        op_write_global_parameter: gl[{op.ctype, op.motor}] = op.value;
        op_read_axis_parameter: held = ax.exists({op.ctype, op.motor}) ?
          ax[{op.ctype, op.motor}] : {16'hC3A5, op.ctype, op.motor};
        op_read_global_parameter: held = gl.exists({op.ctype, op.motor}) ?
          gl[{op.ctype, op.motor}] : {16'h5A3C, op.ctype, op.motor};
        default: held = {24'h0, op.ctype ^ 8'h5A};
      endcase
      if (op.kind inside {op_read_axis_parameter, op_read_global_parameter,
          op_read_input_port}) begin
        wait_n = slow ? $urandom_range(6, 1) : 0;
      end
    end
    if (wait_n == 0) begin
      rsp_valid = 1'b1;
      rsp_data = held;
    end
    if (wait_n >= 0) wait_n = wait_n - 1;
  end
endmodule : mcd_exec_model
`default_nettype wire

// ---- tb/mcd_decoder_test.sv ----
// self-checking bench of the motion command decoder
`timescale 1ns/10ps
`default_nettype none
`include "mcd_defs.svh"
module mcd_decoder_test;
  import mcd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic slow = 1'b0;
  logic irq_entry = 1'b0;
  logic [31:0] actual_pos = 32'h0;
  mcd_cmd_s cmd = '0;
  logic cmd_ready, op_valid, rsp_valid, reply_valid, got_op;
  logic [31:0] rsp_data, acc, xreg, e, w, xe, g, u, p;
  mcd_op_s op, os;
  mcd_reply_s reply, rep;
  int bad_count = 0;
  int n_compared = 0;
  byte unsigned nums[33] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 19, 20, 21, 22,
    23, 24, 25, 26, 27, 28, 30, 31, 32, 33, 34, 35, 37, 38, 39};
  // position of the expected operation kind in the op enum, zero for none
  byte unsigned kix[33] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 0, 0, 15, 16,
    17, 18, 21, 22, 19, 20, 0, 0, 0, 0, 5, 9, 23, 24, 0};
  byte unsigned bad[9] = '{8'h00, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h1D, 8'h24, 8'h28, 8'hFF};
  always #20 ref_clk = ~ref_clk;
  mcd_decoder i_dut (.ref_clk, .rst, .cmd_valid, .cmd, .cmd_ready, .op_valid, .op,
    .rsp_valid, .rsp_data, .actual_pos, .irq_entry, .reply_valid, .reply, .acc, .xreg);
  mcd_exec_model i_exec (.ref_clk, .rst, .op_valid, .op, .slow, .rsp_valid, .rsp_data);
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] alu(input logic [7:0] c, input logic [31:0] a, b);
    case (c)
      8'h00: return a + b;
      8'h01: return a - b;
      8'h02: return a * b;
      8'h03: return a & b;
      8'h04: return a | b;
      8'h05: return a ^ b;
      8'h06: return ~a;
      default: return b;
    endcase
  endfunction : alu
  task automatic chk(input bit ok);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t ns: port result differs", $time);
    end
  endtask : chk
  task automatic results;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // entered just after an edge; returns just after the edge that ends the reply cycle
  task automatic send(input logic sa, input logic [7:0] num, input logic [7:0] ty,
      input logic [7:0] mot, input logic [31:0] val);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{standalone: sa, number: num, ctype: ty, motor: mot, value: val};
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    got_op = op_valid;
    os = op;
    while (reply_valid !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 100) chk(1'b0);
    rep = reply;
    // one edge passes so the next call never raises valid in the step that lowered it
    @(posedge ref_clk);
    #1;
  endtask : send
  // ****************
  // tests
  // ****************
  initial begin
    #(40 * 20000);
    bad_count++;
    results();
  end
  initial begin
    e = $urandom(32'h1bc5fc8a);
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int sa = 0; sa < 2; sa++) begin
      for (int i = 0; i < 33; i++) begin
        if (sa == 0 && nums[i] inside {[20:28]}) continue;
        slow = 1'($urandom_range(1));
        send(sa[0], nums[i], 8'h00, 8'h00, $urandom);
        chk(rep.status === `MCD_ST_OK);
        chk(rep.number === nums[i]);
        chk(got_op === 1'(kix[i] != 0) && (kix[i] == 0 || os.kind === mcd_op_e'(kix[i])));
      end
    end
    e = $urandom;
    send(1'b1, `MCD_CMD_ALU_CONST, 8'h07, 8'h00, e);
    for (int c = 0; c < 8; c++) begin
      w = $urandom;
      e = alu(c[7:0], e, w);
      send(1'b1, `MCD_CMD_ALU_CONST, c[7:0], 8'h00, w);
      chk(acc === e && rep.value === e);
    end
    send(1'b1, `MCD_CMD_ALU_CONST, 8'h08, 8'h00, 32'h0);
    chk(rep.status === `MCD_ST_BAD_TYPE && acc === e);
    send(1'b1, `MCD_CMD_ALU_X, 8'h08, 8'h00, 32'h0);
    chk(xreg === e);
    w = $urandom;
    xe = w + e;
    send(1'b1, `MCD_CMD_ALU_CONST, 8'h07, 8'h00, w);
    send(1'b1, `MCD_CMD_ALU_X, 8'h00, 8'h00, 32'h0);
    chk(acc === xe);
    send(1'b1, `MCD_CMD_ALU_X, 8'h0A, 8'h00, 32'h0);
    chk(acc === e && xreg === xe);
    u = $urandom;
    send(1'b0, `MCD_CMD_WR_AXIS, 8'h04, 8'h01, u);
    slow = 1'b1;
    send(1'b0, `MCD_CMD_RD_AXIS, 8'h04, 8'h01, 32'h0);
    chk(rep.value === u && acc === e);
    send(1'b0, `MCD_CMD_RD_AXIS, 8'h04, 8'h02, 32'h0);
    chk(rep.value === {16'hC3A5, 8'h04, 8'h02});
    slow = 1'b0;
    g = {16'h5A3C, 8'h07, 8'h00};
    send(1'b1, `MCD_CMD_RD_GLOBAL, 8'h07, 8'h00, 32'h0);
    chk(acc === g && rep.value === g);
    send(1'b1, `MCD_CMD_ACC_TO_COORD, 8'h03, 8'h00, 32'h0);
    send(1'b1, `MCD_CMD_ALU_CONST, 8'h07, 8'h00, w);
    send(1'b0, `MCD_CMD_GET_COORD, 8'h03, 8'h00, 32'h0);
    chk(acc === w && rep.value === g);
    send(1'b1, `MCD_CMD_GET_COORD, 8'h03, 8'h00, 32'h0);
    chk(acc === g);
    p = $urandom;
    actual_pos = p;
    send(1'b1, `MCD_CMD_CAPT_COORD, 8'h05, 8'h00, 32'h0);
    actual_pos = ~p;
    send(1'b1, `MCD_CMD_SET_COORD, 8'h02, 8'h00, u);
    send(1'b1, `MCD_CMD_GET_COORD, 8'h05, 8'h00, 32'h0);
    chk(acc === p);
    send(1'b1, `MCD_CMD_GET_COORD, 8'h02, 8'h00, 32'h0);
    chk(acc === u);
    send(1'b1, `MCD_CMD_ACC_TO_COORD, 8'h08, 8'h00, 32'h0);
    chk(rep.status === `MCD_ST_BAD_TYPE);
    send(1'b1, `MCD_CMD_ACC_TO_AXIS, 8'h09, 8'h03, 32'h0);
    send(1'b0, `MCD_CMD_RD_AXIS, 8'h09, 8'h03, 32'h0);
    chk(rep.value === u && acc === u);
    send(1'b1, `MCD_CMD_COMPARE, 8'h00, 8'h00, u);
    send(1'b1, `MCD_CMD_JUMP_COND, 8'h00, 8'h00, 32'h0);
    chk(got_op === 1'b1 && os.taken === 1'b1);
    send(1'b1, `MCD_CMD_JUMP_COND, 8'h01, 8'h00, 32'h0);
    chk(got_op === 1'b1 && os.taken === 1'b0);
    @(posedge ref_clk);
    #1 irq_entry = 1'b1;
    @(posedge ref_clk);
    #1 irq_entry = 1'b0;
    send(1'b1, `MCD_CMD_ALU_CONST, 8'h07, 8'h00, p);
    send(1'b1, `MCD_CMD_RET_IRQ, 8'h00, 8'h00, 32'h0);
    chk(acc === u && xreg === xe);
    foreach (bad[i]) begin
      send(i[0], bad[i], 8'h00, 8'h00, $urandom);
      chk(rep.status === `MCD_ST_BAD_CMD && got_op === 1'b0 && acc === u && xreg === xe);
    end
    results();
  end
endmodule : mcd_decoder_test
`default_nettype wire
